// *** bench/eal_eeprom_model.sv ***
// Purpose: Behavioural two-wire EEPROM of 128 sixteen-bit words
// Assumes: Data line has a pull-up; nack_en withholds every acknowledge
// Notes: Drives data only while the clock is low, so no false start or stop
`timescale 1ns/1ns
module eal_eeprom_model (
	input wire logic scl,
	input wire logic sda,
	input wire logic nack_en,
	output logic sda_pull
);
	import eal_pkg::*;
	logic [15:0] mem [0:127];
	logic [7:0] sh, hi, ob;
	logic [6:0] ptr;
	logic act, hs, mack, snt;
	int cnt, ph;
	initial begin
		sda_pull = 1'b0;
		act = 1'b0;
		for (int i = 0; i < 128; i++) mem[i] = 16'hC000 + 16'(i);
	end
	// Start: the falling clock after it is not a bit, hence -1
	always @(negedge sda) if (scl) begin
		act = 1'b1;
		ph = 0;
		cnt = -1;
		hs = 1'b1;
	end
	always @(posedge sda) if (scl) begin
		act = 1'b0;
		sda_pull = 1'b0;
	end
	always @(posedge scl) if (act) begin
		if (cnt == 8) mack = ~sda;
		else sh = {sh[6:0], sda};
	end
	always @(negedge scl) if (act) begin
		if (cnt == 8) begin
			cnt = 0;
			sda_pull = 1'b0;
			if (ph == 3 && snt) begin
				hs = ~hs;
				if (hs) ptr = ptr + 7'h01;
				if (!mack) ph = 4;
			end
			if (ph == 3) begin
				snt = 1'b1;
				ob = hs ? mem[ptr][15:8] : mem[ptr][7:0];
				sda_pull = ~ob[7];
			end
		end else begin
			cnt++;
			// Master acks in slot 8 of a sent byte, so let go there
			if (ph == 3) sda_pull = (cnt == 8) ? 1'b0 : ~ob[7 - cnt];
			else if (cnt == 8 && ph < 3) begin
				sda_pull = ~nack_en;
				if (ph == 0) begin
					if (sh[7:1] !== DEV_WR_CODE[7:1]) sda_pull = 1'b0;
					ph = sh[0] ? 3 : 1;
					snt = 1'b0;
				end else if (ph == 1) begin
					ptr = sh[7:1];
					ph = 2;
				end else if (!nack_en) begin
					if (hs) hi = sh;
					else mem[ptr] = {hi, sh};
					if (!hs) ptr = ptr + 7'h01;
					hs = ~hs;
				end
			end
		end
	end
endmodule : eal_eeprom_model

// *** bench/eal_top_bench.sv ***
// Purpose: Self-checking bench of the EEPROM autoload and access block
// Assumes: EEPROM model on the link, pull-up on the data line
// Notes: Divider select 3 keeps software cycles near 5k to 6k clocks each
`timescale 1ns/1ns
module eal_top_bench;
	import eal_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	eal_bus_req_type bus_req = '0;
	logic [31:0] rdata, v;
	logic irq, scl_o, sda_o, sda_oe, pull, sda_line;
	logic nack_en = 1'b0;
	eal_cfg_word_type cfg_out;
	eal_cfg_word_type cfgs[$];
	int failures = 0;
	int comparisons = 0;
	int cycles = 0;
	assign sda_line = ~((sda_oe & ~sda_o) | pull);
	always #50 sys_clk = ~sys_clk;
	eal_top DUT (.sys_clk(sys_clk), .rst(rst), .bus_req(bus_req), .rdata(rdata), .irq(irq),
		.cfg_out(cfg_out), .scl_o(scl_o), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe));
	eal_eeprom_model ee (.scl(scl_o), .sda(sda_line), .nack_en(nack_en), .sda_pull(pull));
	// Whole run needs about 32k clocks; twice that means a hang
	always @(posedge sys_clk) begin
		cycles++;
		if (cfg_out.valid === 1'b1) cfgs.push_back(cfg_out);
		if (cycles == 64000) begin
			failures++;
			end_of_test();
		end
	end
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		bus_req.wr <= 1'b0;
		@(posedge sys_clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		bus_req.rd <= 1'b0;
		#1 d = rdata;
		@(posedge sys_clk);
	endtask : rd
	task automatic wait_bit(input int b, input logic val, input int polls);
		for (int i = 0; i < polls; i++) begin
			rd(REG_CTRL_OFS, v);
			if (v[b] === val) return;
			repeat (6) @(posedge sys_clk);
		end
		check("wait_bit", 32'h0, 32'h1);
	endtask : wait_bit
	function automatic logic [31:0] mk(input logic [15:0] d, input logic [6:0] a, input logic cmd);
		return {d, a, 5'h03, 2'h0, cmd, 1'b1};
	endfunction : mk
	task automatic t_autoload();
		wr(REG_CTRL_OFS, 32'h0000_00B0);
		rd(REG_CTRL_OFS, v);
		check("al_busy", v, 32'h0000_01B0);
		wait_bit(ACTIVE_BIT, 1'b0, 400);
		check("al_done", v, 32'h0000_00B8);
		check("al_count", cfgs.size(), 32'h4);
		foreach (cfgs[i]) check("al_word", 32'(cfgs[i]), {8'h00, 1'b1, 7'(i), 16'hC000 + 16'(i)});
		wr(8'h40, 32'hFFFF_FFFF);
		rd(8'h40, v);
		check("unmapped", v, 32'h0);
		rd(REG_IRQ_MASK_OFS, v);
		check("mask_rst", v, 32'h0);
		rd(REG_IRQ_STAT_OFS, v);
		check("al_irq", v, 32'h4);
		wr(REG_IRQ_STAT_OFS, 32'h7);
		$display("test autoload done");
	endtask : t_autoload
	task automatic t_sw_write();
		time t0;
		wr(REG_CTRL_OFS, mk(16'hBEEF, 7'h05, 1'b1));
		@(posedge scl_o);
		t0 = $time;
		@(posedge scl_o);
		check("scl_period", 32'($time - t0), 32'h3200);
		@(posedge sys_clk);
		wait_bit(GO_BIT, 1'b0, 2500);
		check("wr_ctrl", v & 32'hFFFF_FFF7, mk(16'hBEEF, 7'h05, 1'b1) & 32'hFFFF_FFFE);
		check("wr_mem", ee.mem[5], 16'hBEEF);
		rd(REG_IRQ_STAT_OFS, v);
		check("sw_irq", v, 32'h1);
		check("irq_masked", irq, 1'b0);
		wr(REG_IRQ_MASK_OFS, 32'h1);
		check("irq_on", irq, 1'b1);
		wr(REG_IRQ_STAT_OFS, 32'h1);
		check("irq_off", irq, 1'b0);
		wr(REG_IRQ_MASK_OFS, 32'h0);
		$display("test write done");
	endtask : t_sw_write
	task automatic t_sw_read(input logic [6:0] a, input logic [15:0] exp);
		wr(REG_CTRL_OFS, mk(16'h0000, a, 1'b0));
		wait_bit(GO_BIT, 1'b0, 2500);
		check("rd_word", v[31:16], exp);
		check("rd_addr", v[15:9], a);
		check("rd_err", v[ERR_BIT], 1'b0);
		$display("test read done");
	endtask : t_sw_read
	task automatic t_nack();
		time t0;
		nack_en <= 1'b1;
		// Divider select 2 here; the short refused cycle keeps the slow clock affordable
		wr(REG_CTRL_OFS, mk(16'h1234, 7'h09, 1'b1) ^ 32'h0000_0010);
		@(posedge scl_o);
		t0 = $time;
		@(posedge scl_o);
		check("scl_period_sel2", 32'($time - t0), 32'h0001_9000);
		@(posedge sys_clk);
		wait_bit(GO_BIT, 1'b0, 2500);
		check("nack_err", v[ERR_BIT], 1'b1);
		check("nack_mem", ee.mem[9], 16'hC009);
		rd(REG_IRQ_STAT_OFS, v);
		check("nack_irq", v[IRQ_ERR], 1'b1);
		nack_en <= 1'b0;
		$display("test nack done");
	endtask : t_nack
	task automatic t_disable();
		rst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		cfgs.delete();
		rst <= 1'b0;
		wr(REG_CTRL_OFS, 32'h0000_0040);
		repeat (2000) @(posedge sys_clk);
		rd(REG_CTRL_OFS, v);
		check("dis_ctrl", v, 32'h40);
		check("dis_words", cfgs.size(), 32'h0);
		$display("test disable done");
	endtask : t_disable
	task automatic end_of_test();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (3) @(posedge sys_clk);
		check("rst_pins", {cfg_out.valid, irq, scl_o, sda_oe}, 4'h2);
		rst <= 1'b0;
		t_autoload();
		t_sw_write();
		t_sw_read(7'h05, 16'hBEEF);
		t_nack();
		t_sw_read(7'h7F, 16'hC07F);
		t_disable();
		end_of_test();
	end
endmodule : eal_top_bench

// *** verilog/eal_bit_engine.sv ***
// Purpose: Two-wire byte engine: start, stop, write byte, read byte
// Assumes: Data line is open drain with a pull-up outside
// Notes: Data only changes while the serial clock is low, except for the start and stop conditions
`timescale 1ns/1ns
module eal_bit_engine (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic tick,
	input wire logic cmd_valid,
	input wire eal_pkg::eal_op_type cmd,
	input wire logic [7:0] wr_byte,
	input wire logic ack_bit,
	output logic busy,
	output logic done,
	output logic [7:0] rd_byte,
	output logic ack_ok,
	output logic scl_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe
);
	import eal_pkg::*;

	eal_op_type op_reg;
	logic busy_reg;
	logic done_reg;
	logic [1:0] q_reg;
	logic [3:0] bit_reg;
	logic [8:0] sh_reg;
	logic samp_reg;
	logic scl_reg;
	logic sda_reg;
	logic sda_s1_reg;
	logic sda_s2_reg;
	logic last;

	assign last = (q_reg == 2'h3) && (op_reg == OP_START || op_reg == OP_STOP || bit_reg == 4'h8);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sda_s1_reg <= 1'b1;
			sda_s2_reg <= 1'b1;
		end else begin
			sda_s1_reg <= sda_i;
			sda_s2_reg <= sda_s1_reg;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			op_reg <= OP_STOP;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			q_reg <= 2'h0;
			bit_reg <= 4'h0;
			sh_reg <= 9'h1FF;
			samp_reg <= 1'b1;
		end else begin
			done_reg <= 1'b0;
			if (!busy_reg && cmd_valid) begin
				op_reg <= cmd;
				busy_reg <= 1'b1;
				q_reg <= 2'h0;
				bit_reg <= 4'h0;
				sh_reg <= (cmd == OP_READ) ? {8'hFF, ack_bit} : {wr_byte, 1'b1};
			end else if (busy_reg && tick) begin
				q_reg <= q_reg + 2'h1;
				if (q_reg == 2'h2) begin
					samp_reg <= sda_s2_reg;
				end
				if (q_reg == 2'h3) begin
					sh_reg <= {sh_reg[7:0], samp_reg};
					bit_reg <= bit_reg + 4'h1;
				end
				if (last) begin
					busy_reg <= 1'b0;
					done_reg <= 1'b1;
				end
			end
		end
	end

	// Line levels per quarter; idle holds the last levels
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			scl_reg <= 1'b1;
			sda_reg <= 1'b1;
		end else if (busy_reg && tick) begin
			unique case (op_reg)
				OP_START: begin
					scl_reg <= (q_reg == 2'h0) || (q_reg == 2'h1);
					sda_reg <= (q_reg == 2'h0);
				end
				OP_STOP: begin
					scl_reg <= 1'b1;
					sda_reg <= (q_reg != 2'h0);
				end
				default: begin
					scl_reg <= (q_reg == 2'h0) || (q_reg == 2'h1);
					sda_reg <= (q_reg == 2'h3) ? sh_reg[7] : sh_reg[8];
				end
			endcase
		end else if (!busy_reg && cmd_valid) begin
			// Preset data with the clock low, so data never moves beside a clock edge
			scl_reg <= 1'b0;
			sda_reg <= (cmd == OP_WRITE) ? wr_byte[7] : (cmd != OP_STOP);
		end
	end

	a_scl_on_tick: assert property (@(posedge sys_clk) disable iff (rst)
		($changed(scl_reg) && $past(busy_reg)) |-> $past(tick))
		else $error("serial clock moved without a tick");

	assign busy = busy_reg;
	assign done = done_reg;
	assign rd_byte = sh_reg[8:1];
	assign ack_ok = !sh_reg[0];
	assign scl_o = scl_reg;
	assign sda_o = 1'b0;
	assign sda_oe = !sda_reg;
endmodule : eal_bit_engine

// *** verilog/eal_clk_div.sv ***
// Purpose: Quarter-bit tick for the serial EEPROM clock
// Assumes: Select and fast inputs come from the same clock domain
// Notes: One serial bit takes four ticks
`timescale 1ns/1ns
module eal_clk_div (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [1:0] div_sel,
	input wire logic fast,
	output logic tick
);
	import eal_pkg::*;

	logic [12:0] ratio;
	logic [10:0] limit;
	logic [10:0] cnt_reg;

	always_comb begin
		unique case (div_sel)
			2'b00: ratio = DIV_SEL0;
			2'b01: ratio = DIV_SEL1;
			2'b10: ratio = DIV_SEL2;
			2'b11: ratio = DIV_SEL3;
		endcase
		limit = fast ? 11'(ratio >> (2 + FAST_SHIFT)) : 11'(ratio >> 2);
		if (limit == 11'h000) begin
			limit = 11'h001;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt_reg <= 11'h000;
		end else if (cnt_reg + 11'h001 >= limit) begin
			cnt_reg <= 11'h000;
		end else begin
			cnt_reg <= cnt_reg + 11'h001;
		end
	end

	assign tick = (cnt_reg + 11'h001 >= limit);
endmodule : eal_clk_div

// *** verilog/eal_pkg.sv ***
// Purpose: Shared constants and types of the EEPROM autoload and access block
// Assumes: Two-wire serial EEPROM holding 16-bit configuration words
// Notes: Divider figures are ratios of the core clock, applied to sys_clk
package eal_pkg;
	// Register byte offsets
	localparam logic [7:0] REG_CTRL_OFS = 8'h70;
	localparam logic [7:0] REG_IRQ_STAT_OFS = 8'h80;
	localparam logic [7:0] REG_IRQ_MASK_OFS = 8'h84;
	// Control/status field positions
	localparam int GO_BIT = 0;
	localparam int CMD_BIT = 1;
	localparam int ERR_BIT = 2;
	localparam int DONE_BIT = 3;
	localparam int DIV_LO = 4;
	localparam int AL_DIS_BIT = 6;
	localparam int FAST_BIT = 7;
	localparam int ACTIVE_BIT = 8;
	localparam int WADDR_LO = 9;
	localparam int DATA_LO = 16;
	// Interrupt status bit positions
	localparam int IRQ_DONE = 0;
	localparam int IRQ_ERR = 1;
	localparam int IRQ_AL = 2;
	// Reset values
	localparam logic [1:0] DIV_SEL_RST = 2'h0;
	localparam logic [6:0] WADDR_RST = 7'h00;
	localparam logic [15:0] DATA_RST = 16'h0000;
	localparam logic [2:0] IRQ_RST = 3'h0;
	// Divide ratios per select code, and the fast autoload factor
	localparam logic [12:0] DIV_SEL0 = 13'h1000;
	localparam logic [12:0] DIV_SEL1 = 13'h0800;
	localparam logic [12:0] DIV_SEL2 = 13'h0400;
	localparam logic [12:0] DIV_SEL3 = 13'h0080;
	localparam int FAST_SHIFT = 5;
	// Serial protocol
	localparam logic [7:0] DEV_WR_CODE = 8'hA0;
	localparam logic [6:0] AUTOLOAD_WORDS = 7'h04;

	typedef enum logic [1:0] {
		OP_START = 2'b00,
		OP_STOP = 2'b01,
		OP_WRITE = 2'b10,
		OP_READ = 2'b11
	} eal_op_type;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} eal_bus_req_type;

	typedef struct packed {
		logic valid;
		logic [6:0] addr;
		logic [15:0] data;
	} eal_cfg_word_type;
endpackage : eal_pkg

// *** verilog/eal_top.sv ***
// Purpose: EEPROM configuration autoload and software word access
// Assumes: Register port master never issues read and write together
// Notes: Interrupt status bits are write-one-to-clear, set wins
`timescale 1ns/1ns

// Function
// - A 0 to 1 write of the start bit launches one access; command picks read/write.
// - Hardware clears the start bit when its access is finished.
// - Error flag set when any expected acknowledge is missing in a cycle.
// - Autoload-complete bit is 1 only after a successful autoload.
// - Serial clock divides the core clock by 4096, 2048, 1024 or 128.
// - Autoload runs when the disable bit is 0, skipped when it is 1.
// - Fast bit runs the autoload 32 times faster.
// - In-progress bit is 1 exactly while autoload runs.
// - Word-address field bits 15:9 locates the software access.
// - Data field bits 31:16 is the word written by a software write.
module eal_top (
	input wire logic sys_clk,
	input wire logic rst,
	input wire eal_pkg::eal_bus_req_type bus_req,
	output logic [31:0] rdata,
	output logic irq,
	output eal_pkg::eal_cfg_word_type cfg_out,
	output logic scl_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe
);
	import eal_pkg::*;

	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_ISSUE = 2'b01,
		S_WAIT = 2'b10,
		S_FIN = 2'b11
	} eal_state_type;

	eal_state_type state_reg;
	logic go_reg;
	logic cmd_reg;
	logic err_reg;
	logic complete_reg;
	logic [1:0] div_sel_reg;
	logic dis_reg;
	logic fast_reg;
	logic al_reg;
	logic al_pend_reg;
	logic [6:0] waddr_reg;
	logic [15:0] data_reg;
	logic [2:0] irq_stat_reg;
	logic [2:0] irq_mask_reg;
	logic [31:0] rdata_reg;
	eal_cfg_word_type cfg_reg;
	logic [2:0] step_reg;
	logic is_rd_reg;
	logic [6:0] cur_addr_reg;
	logic [15:0] rd_word_reg;

	logic tick;
	logic eng_done;
	logic [7:0] rd_byte;
	logic ack_ok;
	eal_op_type op;
	logic [7:0] wbyte;
	logic ack_bit;
	logic [2:0] stop_step;
	logic [31:0] ctrl_view;
	logic wr_ctrl;
	logic wr_stat;
	logic wr_mask;
	logic start_sw;
	logic start_al;
	logic dis_now;
	logic nack;
	logic [2:0] irq_set;

	assign wr_ctrl = bus_req.wr && bus_req.addr == REG_CTRL_OFS;
	assign wr_stat = bus_req.wr && bus_req.addr == REG_IRQ_STAT_OFS;
	assign wr_mask = bus_req.wr && bus_req.addr == REG_IRQ_MASK_OFS;
	// A disable write in the deciding cycle still counts, else the bit could never skip
	assign dis_now = wr_ctrl ? bus_req.wdata[AL_DIS_BIT] : dis_reg;
	assign start_al = state_reg == S_IDLE && al_pend_reg && !dis_now;
	assign start_sw = state_reg == S_IDLE && !al_pend_reg && go_reg;
	assign stop_step = is_rd_reg ? 3'h7 : 3'h5;
	assign nack = state_reg == S_WAIT && eng_done && op == OP_WRITE && !ack_ok;

	// Autoload speed only affects autoload traffic
	eal_clk_div u_div (
		.sys_clk(sys_clk),
		.rst(rst),
		.div_sel(div_sel_reg),
		.fast(fast_reg && al_reg),
		.tick(tick)
	);

	eal_bit_engine u_eng (
		.sys_clk(sys_clk),
		.rst(rst),
		.tick(tick),
		.cmd_valid(state_reg == S_ISSUE),
		.cmd(op),
		.wr_byte(wbyte),
		.ack_bit(ack_bit),
		.busy(),
		.done(eng_done),
		.rd_byte(rd_byte),
		.ack_ok(ack_ok),
		.scl_o(scl_o),
		.sda_i(sda_i),
		.sda_o(sda_o),
		.sda_oe(sda_oe)
	);

	// Per-step operation of one word transfer
	always_comb begin
		op = OP_STOP;
		wbyte = 8'hFF;
		ack_bit = 1'b1;
		unique case (step_reg)
			3'h0: op = OP_START;
			3'h1: begin
				op = OP_WRITE;
				wbyte = DEV_WR_CODE;
			end
			3'h2: begin
				op = OP_WRITE;
				wbyte = {cur_addr_reg, 1'b0};
			end
			3'h3: begin
				op = is_rd_reg ? OP_START : OP_WRITE;
				wbyte = data_reg[15:8];
			end
			3'h4: begin
				op = OP_WRITE;
				wbyte = is_rd_reg ? (DEV_WR_CODE | 8'h01) : data_reg[7:0];
			end
			3'h5: begin
				op = is_rd_reg ? OP_READ : OP_STOP;
				ack_bit = 1'b0;
			end
			3'h6: op = OP_READ;
			3'h7: op = OP_STOP;
		endcase
	end

	// Access sequencer
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg <= S_IDLE;
			step_reg <= 3'h0;
			is_rd_reg <= 1'b0;
			cur_addr_reg <= WADDR_RST;
			rd_word_reg <= DATA_RST;
		end else begin
			unique case (state_reg)
				S_IDLE: begin
					step_reg <= 3'h0;
					if (start_al) begin
						is_rd_reg <= 1'b1;
						cur_addr_reg <= WADDR_RST;
						state_reg <= S_ISSUE;
					end else if (start_sw) begin
						is_rd_reg <= !cmd_reg;
						cur_addr_reg <= waddr_reg;
						state_reg <= S_ISSUE;
					end
				end
				S_ISSUE: state_reg <= S_WAIT;
				S_WAIT: begin
					if (eng_done) begin
						if (step_reg == 3'h5 && is_rd_reg) begin
							rd_word_reg[15:8] <= rd_byte;
						end
						if (step_reg == 3'h6) begin
							rd_word_reg[7:0] <= rd_byte;
						end
						if (step_reg == stop_step) begin
							state_reg <= S_FIN;
						end else begin
							step_reg <= nack ? stop_step : step_reg + 3'h1;
							state_reg <= S_ISSUE;
						end
					end
				end
				S_FIN: begin
					step_reg <= 3'h0;
					if (al_reg && !err_reg && cur_addr_reg + 7'h01 < AUTOLOAD_WORDS) begin
						cur_addr_reg <= cur_addr_reg + 7'h01;
						state_reg <= S_ISSUE;
					end else begin
						state_reg <= S_IDLE;
					end
				end
			endcase
		end
	end

	// Autoload bookkeeping
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			al_pend_reg <= 1'b1;
			al_reg <= 1'b0;
			complete_reg <= 1'b0;
		end else begin
			if (state_reg == S_IDLE && al_pend_reg) begin
				al_pend_reg <= 1'b0;
				al_reg <= !dis_now;
				complete_reg <= 1'b0;
			end else if (state_reg == S_FIN && al_reg &&
				(err_reg || cur_addr_reg + 7'h01 >= AUTOLOAD_WORDS)) begin
				al_reg <= 1'b0;
				complete_reg <= !err_reg;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cfg_reg <= '0;
		end else begin
			cfg_reg.valid <= state_reg == S_FIN && al_reg && !err_reg;
			cfg_reg.addr <= cur_addr_reg;
			cfg_reg.data <= rd_word_reg;
		end
	end

	// Error flag reflects the latest cycle only
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			err_reg <= 1'b0;
		end else if (start_al || start_sw) begin
			err_reg <= 1'b0;
		end else if (nack) begin
			err_reg <= 1'b1;
		end
	end

	// Start bit: only a 0 to 1 write arms a cycle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			go_reg <= 1'b0;
		end else if (state_reg == S_FIN && !al_reg) begin
			go_reg <= 1'b0;
		end else if (wr_ctrl && bus_req.wdata[GO_BIT] && !go_reg) begin
			go_reg <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cmd_reg <= 1'b0;
			div_sel_reg <= DIV_SEL_RST;
			dis_reg <= 1'b0;
			fast_reg <= 1'b0;
			waddr_reg <= WADDR_RST;
		end else if (wr_ctrl) begin
			cmd_reg <= bus_req.wdata[CMD_BIT];
			div_sel_reg <= bus_req.wdata[DIV_LO +: 2];
			dis_reg <= bus_req.wdata[AL_DIS_BIT];
			fast_reg <= bus_req.wdata[FAST_BIT];
			waddr_reg <= bus_req.wdata[WADDR_LO +: 7];
		end
	end

	// Read result beats a software write landing in the same cycle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			data_reg <= DATA_RST;
		end else if (state_reg == S_FIN && !al_reg && is_rd_reg && !err_reg) begin
			data_reg <= rd_word_reg;
		end else if (wr_ctrl) begin
			data_reg <= bus_req.wdata[DATA_LO +: 16];
		end
	end

	// Interrupt status and mask
	always_comb begin
		irq_set = 3'h0;
		irq_set[IRQ_DONE] = state_reg == S_FIN && !al_reg;
		irq_set[IRQ_ERR] = nack;
		irq_set[IRQ_AL] = state_reg == S_FIN && al_reg && (err_reg || cur_addr_reg + 7'h01 >= AUTOLOAD_WORDS);
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irq_stat_reg <= IRQ_RST;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~(wr_stat ? bus_req.wdata[2:0] : 3'h0)) | irq_set;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irq_mask_reg <= IRQ_RST;
		end else if (wr_mask) begin
			irq_mask_reg <= bus_req.wdata[2:0];
		end
	end

	always_comb begin
		ctrl_view = 32'h0000_0000;
		ctrl_view[GO_BIT] = go_reg;
		ctrl_view[CMD_BIT] = cmd_reg;
		ctrl_view[ERR_BIT] = err_reg;
		ctrl_view[DONE_BIT] = complete_reg;
		ctrl_view[DIV_LO +: 2] = div_sel_reg;
		ctrl_view[AL_DIS_BIT] = dis_reg;
		ctrl_view[FAST_BIT] = fast_reg;
		ctrl_view[ACTIVE_BIT] = al_reg;
		ctrl_view[WADDR_LO +: 7] = waddr_reg;
		ctrl_view[DATA_LO +: 16] = data_reg;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rdata_reg <= 32'h0000_0000;
		end else if (bus_req.rd) begin
			unique case (bus_req.addr)
				REG_CTRL_OFS: rdata_reg <= ctrl_view;
				REG_IRQ_STAT_OFS: rdata_reg <= {29'h0000_0000, irq_stat_reg};
				REG_IRQ_MASK_OFS: rdata_reg <= {29'h0000_0000, irq_mask_reg};
				default: rdata_reg <= 32'h0000_0000;
			endcase
		end else begin
			rdata_reg <= 32'h0000_0000;
		end
	end

	assign rdata = rdata_reg;
	assign irq = |(irq_stat_reg & irq_mask_reg);
	assign cfg_out = cfg_reg;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_start_runs: assert property ($rose(go_reg) && !al_reg && !al_pend_reg |-> ##[0:2] state_reg == S_ISSUE)
		else $error("start bit did not launch an access");
	a_go_self_clear: assert property (state_reg == S_FIN && !al_reg |=> !go_reg)
		else $error("start bit not cleared at finish");
	a_nack_error: assert property (nack |=> err_reg ##1 (step_reg == stop_step))
		else $error("missing acknowledge not flagged");
	a_complete_ok: assert property ($rose(complete_reg) |-> $past(al_reg) && !err_reg)
		else $error("autoload complete without success");
	a_skip_dis: assert property (state_reg == S_IDLE && al_pend_reg && dis_now |=> !al_reg [*3])
		else $error("autoload ran while disabled");
	a_active_busy: assert property (al_reg |-> state_reg != S_IDLE)
		else $error("autoload flagged while idle");
	a_addr_byte: assert property (state_reg == S_ISSUE && step_reg == 3'h2 && !al_reg
		|-> wbyte == {$past(waddr_reg, 1), 1'b0} || $changed(waddr_reg))
		else $error("address byte differs from word field");
	a_data_byte: assert property (state_reg == S_ISSUE && step_reg == 3'h3 && !is_rd_reg
		|-> wbyte == data_reg[15:8])
		else $error("data byte differs from data field");
	a_read_load: assert property (state_reg == S_FIN && !al_reg && is_rd_reg && !err_reg
		|=> data_reg == $past(rd_word_reg))
		else $error("read word not placed in data field");

	c_sw_read: cover property (state_reg == S_FIN && !al_reg && is_rd_reg);
	c_sw_write: cover property (state_reg == S_FIN && !al_reg && !is_rd_reg);
	c_al_done: cover property ($rose(complete_reg));
	c_nack: cover property (nack);
	c_al_skip: cover property (state_reg == S_IDLE && al_pend_reg && dis_now);
endmodule : eal_top
